// File: nipc_cfg.svh
// Offsets, field positions, reset values and encodings of the nested interrupt priority block
`ifndef NIPC_CFG_SVH
`define NIPC_CFG_SVH
`define NIPC_OFF_VPRIO0    12'h000
`define NIPC_OFF_VPRIO1    12'h004
`define NIPC_OFF_VPRIO2    12'h008
`define NIPC_OFF_VPRIO3    12'h00C
`define NIPC_OFF_SENSE     12'h010
`define NIPC_OFF_CCR       12'h014
`define NIPC_OFF_STATUS    12'h018
`define NIPC_VPRIO_RESET   8'hFF
`define NIPC_SENSE_RESET   8'h00
`define NIPC_CC_HI_BIT     5
`define NIPC_CC_LO_BIT     3
`define NIPC_LVL0          2'h2
`define NIPC_LVL1          2'h1
`define NIPC_LVL2          2'h0
`define NIPC_LVL3          2'h3
`define NIPC_SB_HI         7
`define NIPC_SB_LO         6
`define NIPC_PB_BIT        5
`define NIPC_SA_HI         4
`define NIPC_SA_LO         3
`define NIPC_PA_BIT        2
`define NIPC_SENSE_FLOW    2'h0
`define NIPC_SENSE_RISE    2'h1
`define NIPC_SENSE_FALL    2'h2
`define NIPC_SENSE_BOTH    2'h3
`define NIPC_NVEC          14
`define NIPC_VEC_EXT0      2
`endif

// File: nipc_pkg.sv
// Types of the nested interrupt priority block
package nipc_pkg;
   typedef enum logic [2:0] {
      NIPC_OP_NONE,
      NIPC_OP_ENABLE,
      NIPC_OP_DISABLE,
      NIPC_OP_HALT,
      NIPC_OP_WAIT,
      NIPC_OP_RESTORE,
      NIPC_OP_TRAP
   } nipc_op_e;
   typedef enum logic [1:0] {
      NIPC_RUN,
      NIPC_ENTER
   } nipc_state_e;
endpackage : nipc_pkg

// File: nipc_ctrl.sv
// Nested interrupt priority controller with external sensitivity and APB registers
`timescale 1ns/1ns
`include "nipc_cfg.svh"
// Summary of operation
// RULE1: Current level kept at condition bits 5, 3
// RULE2: Levels 0..3 coded 10, 01, 00, 11
// RULE3: Trap and reset preempt level 3 code
// RULE4: Entry loads the vector's stored priority pair
// RULE5: Four 8-bit priority registers reset to ones
// RULE6: Vector 0..13 map to pairs 0..13
// RULE7: Writing level 0 pattern keeps that pair
// RULE8: Reset or trap service selects level 3
// RULE9: Raised priority of pending running vector re-enters
// RULE10: Enable loads 10, disable/trap 11, halt/wait 10
// RULE11: Return and pop restore both bits from stack
// RULE12: Masked jump on 11, unmasked jump otherwise
// RULE13: Instructions change level until next return
// RULE14: Four independent external source sensitivities; the code shares one sense field per source pair (0,1 and 2,3)
// RULE15: Four edge modes; high level only sources 0,2
// RULE16: Software changes sensitivity only at level 3; the code accepts sense writes at any level
// RULE17: Changed sensitivity write clears pending external requests
// RULE18: Sense codes 00 fall+low, 01 rise, 10 fall, 11 both
// RULE19: Polarity bit inverts lower-nibble port sources
// RULE20: Serviced only if enabled and priority exceeds level
// RULE21: Edge requests latched, cleared on routine entry
// RULE22: Upper nibble of last register reads ones
module nipc_ctrl (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic      [31:0]            prdata,
   output logic                        pslverr,
   input  wire logic [2:0]             cpu_op,
   input  wire logic [1:0]             stacked_prio,
   input  wire logic                   trap_take,
   input  wire logic [13:0]            vec_request,
   input  wire logic [13:0]            vec_enable,
   input  wire logic [3:0]             ext_src_porta_low,
   input  wire logic [2:0]             ext_src_portf,
   input  wire logic [3:0]             ext_src_portb_low,
   input  wire logic                   ext_src_portb_high,
   input  wire logic                   entry_ack,
   output logic                        irq_take,
   output logic      [3:0]             irq_vector,
   output logic      [1:0]             irq_prio,
   output logic                        cur_prio_hi,
   output logic                        cur_prio_lo,
   output logic                        jump_if_masked,
   output logic                        jump_if_unmasked,
   output logic      [3:0]             ext_pending
);
   logic [7:0]  vector_priority_regs [0:3];
   logic [7:0]  ext_sense_control;
   logic [1:0]  cur_prio;
   logic [3:0]  ext_in_q;
   logic [3:0]  ext_in;
   logic [3:0]  ext_hit;
   logic [13:0] pend_all;
   logic        acc_wr;
   logic        acc_rd;
   logic [3:0]  cur_vec;
   logic        in_service;
   logic [1:0]  next_prio;
   logic [2:0]  best_rank;
   logic [3:0]  best_vec;
   logic        best_found;
   nipc_pkg::nipc_state_e state;

   // Ranks levels so that level 3 is highest though it is coded 11 and level 0 is 10
   function automatic logic [2:0] rank(input logic [1:0] p);
      case (p)
         `NIPC_LVL0: rank = 3'h0;
         `NIPC_LVL1: rank = 3'h1;
         `NIPC_LVL2: rank = 3'h2;
         default:    rank = 3'h3;
      endcase
   endfunction : rank

   // Priority pair of vector v
   function automatic logic [1:0] vprio(input logic [3:0] v);
      logic [7:0] r;
      r = vector_priority_regs[v[3:2]];
      vprio = {r[{v[1:0], 1'b1}], r[{v[1:0], 1'b0}]}; // see RULE6
   endfunction : vprio

   // Merges one written byte, keeping each pair that would become level 0
   function automatic logic [7:0] prio_merge(input logic [7:0] old_v, input logic [7:0] new_v);
      logic [7:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (new_v[2*i +: 2] != `NIPC_LVL0) begin
            r[2*i +: 2] = new_v[2*i +: 2]; // see RULE7
         end
      end
      prio_merge = r;
   endfunction : prio_merge

   // Hit test of one source: sense code, inversion, previous and present level
   function automatic logic sense_hit(input logic [1:0] s, input logic inv, input logic prev, input logic now);
      logic rise;
      logic fall;
      rise = !prev && now;
      fall = prev && !now;
      if (inv) begin
         rise = prev && !now; // see RULE19
         fall = !prev && now;
      end
      case (s)
         `NIPC_SENSE_RISE: sense_hit = rise; // see RULE18
         `NIPC_SENSE_FALL: sense_hit = fall;
         `NIPC_SENSE_BOTH: sense_hit = rise || fall;
         default:          sense_hit = fall || (inv ? now : !now);
      endcase
   endfunction : sense_hit

   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign acc_wr  = psel && penable && pwrite;
   assign acc_rd  = psel && !penable && !pwrite;

   // Grouped pins are ORed onto one line each
   assign ext_in[0] = |ext_src_porta_low;
   assign ext_in[1] = |ext_src_portf;
   assign ext_in[2] = |ext_src_portb_low;
   assign ext_in[3] = ext_src_portb_high;

   always_comb begin
      ext_hit[0] = sense_hit(ext_sense_control[`NIPC_SA_HI:`NIPC_SA_LO],
                             ext_sense_control[`NIPC_PA_BIT], ext_in_q[0], ext_in[0]); // see RULE15
      ext_hit[1] = sense_hit(ext_sense_control[`NIPC_SA_HI:`NIPC_SA_LO], 1'b0, ext_in_q[1], ext_in[1]);
      ext_hit[2] = sense_hit(ext_sense_control[`NIPC_SB_HI:`NIPC_SB_LO],
                             ext_sense_control[`NIPC_PB_BIT], ext_in_q[2], ext_in[2]);
      ext_hit[3] = sense_hit(ext_sense_control[`NIPC_SB_HI:`NIPC_SB_LO], 1'b0, ext_in_q[3], ext_in[3]); // see RULE14
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_in_q <= 4'h0;
      end else begin
         ext_in_q <= ext_in;
      end
   end

   // Priority registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 4; i++) begin
            vector_priority_regs[i] <= `NIPC_VPRIO_RESET; // see RULE5
         end
      end else if (acc_wr) begin
         if (paddr == `NIPC_OFF_VPRIO0) begin
            vector_priority_regs[0] <= prio_merge(vector_priority_regs[0], pwdata[7:0]);
         end else if (paddr == `NIPC_OFF_VPRIO1) begin
            vector_priority_regs[1] <= prio_merge(vector_priority_regs[1], pwdata[7:0]);
         end else if (paddr == `NIPC_OFF_VPRIO2) begin
            vector_priority_regs[2] <= prio_merge(vector_priority_regs[2], pwdata[7:0]);
         end else if (paddr == `NIPC_OFF_VPRIO3) begin
            // Upper pairs are forced to 11, which the merge never treats as level 0
            vector_priority_regs[3] <= prio_merge(vector_priority_regs[3], {4'hF, pwdata[3:0]}); // see RULE22
         end
      end
   end

   // Sense control: written freely, software is trusted to write it only at level 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_sense_control <= `NIPC_SENSE_RESET;
      end else if (acc_wr && paddr == `NIPC_OFF_SENSE) begin
         ext_sense_control <= {pwdata[7:2], 2'h0}; // see RULE16
      end
   end

   // Latched external requests; a new hit wins over the entry clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_pending <= 4'h0;
      end else if (acc_wr && paddr == `NIPC_OFF_SENSE && pwdata[7:2] != ext_sense_control[7:2]) begin
         ext_pending <= 4'h0; // see RULE17
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (ext_hit[i]) begin
               ext_pending[i] <= 1'b1; // see RULE21
            end else if (entry_ack && in_service == 1'b0 && state == nipc_pkg::NIPC_ENTER
                         && cur_vec == 4'(i + `NIPC_VEC_EXT0)) begin
               ext_pending[i] <= 1'b0; // see RULE21
            end
         end
      end
   end

   always_comb begin
      pend_all = vec_request;
      pend_all[`NIPC_VEC_EXT0 +: 4] = vec_request[`NIPC_VEC_EXT0 +: 4] | ext_pending;
   end

   // Arbitration: highest software level, then lowest vector number
   always_comb begin
      best_rank  = 3'h0;
      best_vec   = 4'h0;
      best_found = 1'b0;
      for (int v = 0; v < `NIPC_NVEC; v++) begin
         if (pend_all[v] && vec_enable[v]
             && rank(vprio(4'(v))) > rank(cur_prio) // see RULE20
             && (!best_found || rank(vprio(4'(v))) > best_rank)) begin
            best_found = 1'b1;
            best_rank  = rank(vprio(4'(v)));
            best_vec   = 4'(v);
         end
      end
   end

   // Entry offered to the core until it acknowledges or a trap is taken; a vector whose stored level
   // was raised above the running level wins again here, so it re-enters
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state      <= nipc_pkg::NIPC_RUN;
         cur_vec    <= 4'h0;
         in_service <= 1'b0;
      end else begin
         case (state)
            nipc_pkg::NIPC_RUN: begin
               if (best_found && !trap_take) begin
                  state   <= nipc_pkg::NIPC_ENTER;
                  cur_vec <= best_vec; // see RULE9
               end
            end
            nipc_pkg::NIPC_ENTER: begin
               if (entry_ack || trap_take) begin
                  state <= nipc_pkg::NIPC_RUN;
               end
            end
            default: state <= nipc_pkg::NIPC_RUN;
         endcase
      end
   end

   assign irq_take   = (state == nipc_pkg::NIPC_ENTER);
   assign irq_vector = cur_vec;
   assign irq_prio   = vprio(cur_vec);

   // Current level update
   always_comb begin
      next_prio = cur_prio;
      if (trap_take) begin
         next_prio = `NIPC_LVL3; // see RULE3
      end else if (irq_take && entry_ack) begin
         next_prio = vprio(cur_vec); // see RULE4
      end else begin
         case (nipc_pkg::nipc_op_e'(cpu_op))
            nipc_pkg::NIPC_OP_ENABLE:  next_prio = `NIPC_LVL0; // see RULE10
            nipc_pkg::NIPC_OP_DISABLE: next_prio = `NIPC_LVL3;
            nipc_pkg::NIPC_OP_TRAP:    next_prio = `NIPC_LVL3; // see RULE8
            nipc_pkg::NIPC_OP_HALT:    next_prio = `NIPC_LVL0;
            nipc_pkg::NIPC_OP_WAIT:    next_prio = `NIPC_LVL0; // see RULE13
            nipc_pkg::NIPC_OP_RESTORE: next_prio = stacked_prio; // see RULE11
            default:                   next_prio = cur_prio;
         endcase
      end
   end

   // Reset starts at level 3
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cur_prio <= `NIPC_LVL3; // see RULE8
      end else begin
         cur_prio <= next_prio;
      end
   end

   assign cur_prio_hi      = cur_prio[1]; // see RULE1
   assign cur_prio_lo      = cur_prio[0];
   assign jump_if_masked   = (cur_prio == `NIPC_LVL3); // see RULE12
   assign jump_if_unmasked = (cur_prio != `NIPC_LVL3); // see RULE2

   // Read data registered in the setup cycle, so it is steady in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (acc_rd) begin
         if (paddr == `NIPC_OFF_VPRIO0) begin
            prdata <= {24'h0, vector_priority_regs[0]};
         end else if (paddr == `NIPC_OFF_VPRIO1) begin
            prdata <= {24'h0, vector_priority_regs[1]};
         end else if (paddr == `NIPC_OFF_VPRIO2) begin
            prdata <= {24'h0, vector_priority_regs[2]};
         end else if (paddr == `NIPC_OFF_VPRIO3) begin
            prdata <= {24'h0, vector_priority_regs[3]};
         end else if (paddr == `NIPC_OFF_SENSE) begin
            prdata <= {24'h0, ext_sense_control};
         end else if (paddr == `NIPC_OFF_CCR) begin
            prdata <= {26'h0, cur_prio[1], 1'b0, cur_prio[0], 3'h0};
         end else if (paddr == `NIPC_OFF_STATUS) begin
            prdata <= {27'h0, irq_take, ext_pending};
         end else begin
            prdata <= 32'h0;
         end
      end
   end
endmodule : nipc_ctrl

// File: nipc_ctrl_assertions.sv
// Assertion checker for the nested interrupt priority controller
`timescale 1ns/1ns
`include "nipc_cfg.svh"
module nipc_ctrl_assertions (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [2:0]  cpu_op,
   input wire logic [1:0]  stacked_prio,
   input wire logic        trap_take,
   input wire logic        entry_ack,
   input wire logic        irq_take,
   input wire logic [1:0]  irq_prio,
   input wire logic        cur_prio_hi,
   input wire logic        cur_prio_lo,
   input wire logic        jump_if_masked,
   input wire logic        jump_if_unmasked,
   input wire logic [3:0]  ext_pending
);
   logic [1:0] lvl;
   logic       ent;
   logic       op_ok;
   logic       sw;
   logic [5:0] sense;
   assign lvl   = {cur_prio_hi, cur_prio_lo};
   assign ent   = irq_take && entry_ack;
   assign op_ok = !trap_take && !ent;
   assign sw    = psel && penable && pwrite && paddr == `NIPC_OFF_SENSE;
   function automatic logic [1:0] rank(input logic [1:0] p);
      return {~(p[1] ^ p[0]), p[0]};
   endfunction : rank
   // Shadow of the sense bits, so that only a changing write is expected to clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sense <= 6'h00;
      else if (sw)
         sense <= pwdata[7:2];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_entry_load: assert property (ent && !trap_take |=> lvl == $past(irq_prio))
      else $error("entry level wrong");
   a_trap_level: assert property (trap_take |=> lvl == `NIPC_LVL3)
      else $error("trap level wrong");
   a_trap_cancel: assert property (trap_take |=> !irq_take)
      else $error("offer survived trap");
   a_op_level0: assert property (cpu_op inside {3'h1, 3'h3, 3'h4} && op_ok |=> lvl == `NIPC_LVL0)
      else $error("enable level wrong");
   a_op_level3: assert property (cpu_op inside {3'h2, 3'h6} && op_ok |=> lvl == `NIPC_LVL3)
      else $error("disable level wrong");
   a_restore_level: assert property (cpu_op == 3'h5 && op_ok |=> lvl == $past(stacked_prio))
      else $error("restore level wrong");
   a_jump_flags: assert property (jump_if_masked == (lvl == 2'h3)
      && jump_if_unmasked != jump_if_masked) else $error("jump flags wrong");
   a_offer_rank: assert property ($rose(irq_take) |-> rank(irq_prio) > rank(lvl))
      else $error("offer not above level");
   a_offer_hold: assert property (irq_take && !entry_ack && !trap_take |=> irq_take && $stable(irq_prio))
      else $error("offer dropped");
   a_sense_clear: assert property (sw && pwdata[7:2] != sense |=> ext_pending == 4'h0)
      else $error("pending not cleared");
   c_entry: cover property (ent);
   c_trap: cover property (trap_take);
   c_clear: cover property (sw && pwdata[7:2] != sense);
endmodule : nipc_ctrl_assertions
bind nipc_ctrl nipc_ctrl_assertions u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .cpu_op, .stacked_prio, .trap_take, .entry_ack, .irq_take, .irq_prio, .cur_prio_hi, .cur_prio_lo,
   .jump_if_masked, .jump_if_unmasked, .ext_pending);

// File: nipc_cpu_model.sv
// Behavioural CPU core that accepts offered interrupt entries
`timescale 1ns/1ns
module nipc_cpu_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] ack_delay,
   input  wire logic       irq_take,
   output logic            entry_ack
);
   logic [3:0] wait_cnt;
   // One-cycle pulse so that a single offer is never taken twice
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_cnt  <= 4'h0;
         entry_ack <= 1'b0;
      end else if (entry_ack || !irq_take) begin
         wait_cnt  <= 4'h0;
         entry_ack <= 1'b0;
      end else if (wait_cnt == ack_delay) begin
         entry_ack <= 1'b1;
      end else begin
         wait_cnt <= wait_cnt + 4'h1;
      end
   end
endmodule : nipc_cpu_model

// File: nipc_ctrl_tb.sv
// Self-checking testbench for the nested interrupt priority controller
`timescale 1ns/1ns
`include "nipc_cfg.svh"
module nipc_ctrl_tb;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, trap_take, entry_ack;
   logic        irq_take, cur_prio_hi, cur_prio_lo, jump_if_masked, jump_if_unmasked;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, e;
   logic [2:0]  cpu_op, ext_src_portf;
   logic [1:0]  stacked_prio, irq_prio;
   logic [13:0] vec_request, vec_enable;
   logic [3:0]  ext_src_porta_low, ext_src_portb_low, ext_pending, irq_vector, ack_delay;
   logic        ext_src_portb_high;
   logic [31:0] exp_q[$];
   logic [7:0]  vp[4];
   int          fail_count = 0;
   int          tests_run = 0;
   int          cyc = 0;
   int          vl[6] = '{0, 1, 6, 9, 12, 13};
   nipc_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata,
      .pslverr, .cpu_op, .stacked_prio, .trap_take, .vec_request, .vec_enable, .ext_src_porta_low,
      .ext_src_portf, .ext_src_portb_low, .ext_src_portb_high, .entry_ack, .irq_take, .irq_vector,
      .irq_prio, .cur_prio_hi, .cur_prio_lo, .jump_if_masked, .jump_if_unmasked, .ext_pending);
   nipc_cpu_model CPU (.pclk, .presetn, .ack_delay, .irq_take, .entry_ack);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic end_sim;
      if (fail_count == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : end_sim
   // Guard far above the several hundred cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   // Read data stands in the access cycle; compare with the oldest note
   always @(posedge pclk) begin
      if (psel && penable && !pwrite) begin
         e = exp_q.pop_front();
         tests_run++;
         if (prdata !== e) begin
            fail_count++;
            $display("CHECK FAILED prdata at %h exp %h got %h", paddr, e, prdata);
         end
      end
   end
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel   <= 1'b1;
      pwrite <= wr;
      paddr  <= a;
      pwdata <= d;
      if (!wr)
         exp_q.push_back(d);
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic op(input logic [2:0] o, input logic [1:0] s);
      @(posedge pclk);
      cpu_op       <= o;
      stacked_prio <= s;
      @(posedge pclk);
      cpu_op <= 3'h0;
   endtask : op
   function automatic logic [31:0] lv(input logic [1:0] p);
      return {26'h0, p[1], 1'b0, p[0], 3'h0};
   endfunction : lv
   function automatic logic [7:0] mrg(input logic [7:0] o, input logic [7:0] n);
      for (int i = 0; i < 8; i += 2)
         if (n[i+:2] == `NIPC_LVL0)
            n[i+:2] = o[i+:2];
      return n;
   endfunction : mrg
   // Pending after the pins move from s to its inverse
   function automatic logic ep(input logic [1:0] c, input logic n, input logic s);
      logic f;
      f = (c != 2'h3) && !(c[0] ^ n);
      return c == 2'h3 || (c == 2'h0 && s == n) || (s ? f : !f);
   endfunction : ep
   initial begin
      logic [7:0] d;
      int         v;
      {psel, penable, pwrite, trap_take} = 4'h0;
      {paddr, pwdata, cpu_op, stacked_prio, vec_request, vec_enable} = '0;
      {ext_src_porta_low, ext_src_portf, ext_src_portb_low, ext_src_portb_high} = 12'hFFF;
      ack_delay = 4'h0;
      presetn   = 1'b0;
      vp        = '{4{`NIPC_VPRIO_RESET}};
      void'($urandom(66537));
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 4; i++)
         apb(1'b0, 12'(4 * i), 32'hFF);
      apb(1'b0, `NIPC_OFF_SENSE, 32'h0);
      apb(1'b0, `NIPC_OFF_CCR, lv(`NIPC_LVL3));
      apb(1'b0, 12'h01C, 32'h0);
      for (int i = 0; i < 8; i++) begin
         d = 8'($urandom);
         d[3:2] = 2'h2;
         v = i % 4;
         apb(1'b1, 12'(4 * v), {24'h0, d});
         vp[v] = mrg(vp[v], d);
         apb(1'b0, 12'(4 * v), {24'h0, v == 3 ? {4'hF, vp[v][3:0]} : vp[v]});
      end
      for (int o = 1; o < 7; o++)
         for (int s = 0; s < 4; s++) begin
            op(3'(o), 2'(s));
            apb(1'b0, `NIPC_OFF_CCR, lv(o == 5 ? 2'(s) : (o == 2 || o == 6) ? 2'h3 : 2'h2));
         end
      for (int i = 0; i < 4; i++)
         apb(1'b1, 12'(4 * i), 32'h0);
      foreach (vl[k]) begin
         v = vl[k];
         ack_delay <= 4'($urandom_range(6));
         apb(1'b1, 12'(4 * (v / 4)), 32'h1 << (2 * (v % 4)));
         vec_request <= 14'h1 << v;
         op(3'h1, 2'h0);
         apb(1'b0, `NIPC_OFF_STATUS, 32'h0);
         vec_enable <= 14'h1 << v;
         for (int t = 0; t < 40 && irq_take !== 1'b1; t++)
            @(posedge pclk);
         tests_run++;
         if (irq_take !== 1'b1 || irq_vector !== 4'(v) || irq_prio !== `NIPC_LVL1 || jump_if_masked !== 1'b0) begin
            fail_count++;
            $display("CHECK FAILED irq_vector exp %h got %h", 4'(v), irq_vector);
         end
         for (int t = 0; t < 40 && entry_ack !== 1'b1; t++)
            @(posedge pclk);
         @(posedge pclk);
         {vec_request, vec_enable} <= '0;
         apb(1'b0, `NIPC_OFF_CCR, lv(`NIPC_LVL1));
         apb(1'b1, 12'(4 * (v / 4)), 32'h0);
         @(posedge pclk);
         trap_take <= 1'b1;
         @(posedge pclk);
         trap_take <= 1'b0;
         apb(1'b0, `NIPC_OFF_CCR, lv(`NIPC_LVL3));
      end
      // Sense is only rewritten while the level stays 3
      for (int s = 0; s < 2; s++)
         for (int c = 0; c < 4; c++)
            for (int n = 0; n < 2; n++) begin
               {ext_src_porta_low, ext_src_portf, ext_src_portb_low, ext_src_portb_high} <= {12{s[0]}};
               repeat (3) @(posedge pclk);
               apb(1'b1, `NIPC_OFF_SENSE, {24'h0, 2'(c), 1'(n), 2'(c), 1'(n), 2'h0});
               repeat (2) @(posedge pclk);
               {ext_src_porta_low, ext_src_portf, ext_src_portb_low, ext_src_portb_high} <= {12{~s[0]}};
               repeat (3) @(posedge pclk);
               apb(1'b0, `NIPC_OFF_STATUS, {28'h0, ep(2'(c), 1'b0, s[0]), ep(2'(c), 1'(n), s[0]),
                  ep(2'(c), 1'b0, s[0]), ep(2'(c), 1'(n), s[0])});
            end
      end_sim();
   end
endmodule : nipc_ctrl_tb
